// [design/clk_mode_pkg.sv]
// constants, mode codes and carrier types for the cpu clock mode selector
// assumes a single core clock that oversamples the oscillator input
package clk_mode_pkg;

  // position of the mode field inside the reset configuration latch
  localparam int CFG_MSB = 7;
  localparam int CFG_LSB = 5;
  // upper byte of the software reset control word
  localparam int RSTCTL_MSB = 15;
  localparam int RSTCTL_LSB = 8;

  // latch value after reset: all ones selects the default multiply by 4
  localparam logic [7:0] RESET_CONFIG_RESET = 8'hFF;

  // mode field encodings
  localparam logic [2:0] MODE_X4 = 3'h7;
  localparam logic [2:0] MODE_X3 = 3'h6;
  localparam logic [2:0] MODE_X2 = 3'h5;
  localparam logic [2:0] MODE_X5 = 3'h4;
  localparam logic [2:0] MODE_DIRECT = 3'h3;
  localparam logic [2:0] MODE_X1P5 = 3'h2;
  localparam logic [2:0] MODE_PRESCALE = 3'h1;
  localparam logic [2:0] MODE_X2P5 = 3'h0;

  // width of the oscillator span counter and smoothing of the rate estimate
  localparam int SPAN_W_DEFAULT = 16;
  localparam int SMOOTH_SHIFT = 2;

  // multiplication factor in halves (1.5 -> 3), zero for non-pll modes
  function automatic logic [3:0] factor_halves(input logic [2:0] mode);
    case (mode)
      MODE_X4: factor_halves = 4'h8;
      MODE_X3: factor_halves = 4'h6;
      MODE_X2: factor_halves = 4'h4;
      MODE_X5: factor_halves = 4'hA;
      MODE_X1P5: factor_halves = 4'h3;
      MODE_X2P5: factor_halves = 4'h5;
      default: factor_halves = 4'h0;
    endcase
  endfunction

  // oscillator transitions between resync points: factor rounded up
  function automatic logic [2:0] resync_count(input logic [2:0] mode);
    case (mode)
      MODE_X4: resync_count = 3'h4;
      MODE_X3: resync_count = 3'h3;
      MODE_X2: resync_count = 3'h2;
      MODE_X5: resync_count = 3'h5;
      MODE_X1P5: resync_count = 3'h2;
      MODE_X2P5: resync_count = 3'h3;
      default: resync_count = 3'h1;
    endcase
  endfunction

  typedef enum logic [2:0] {
    ST_RESTART,
    ST_DIRECT,
    ST_PRESCALE,
    ST_PLL_ACQUIRE,
    ST_PLL_LOCKED
  } gen_state_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
    logic half_tick;
  } cpu_clock_t;

  typedef struct packed {
    logic pll_enable;
    logic pll_locked;
    logic prescale_active;
    logic direct_active;
  } clock_status_t;

endpackage

// [design/cpu_clock_mode_select.sv]
// cpu clock mode selector: latches the clock configuration and generates
// the cpu clock level with its edge pulses from the oscillator input
// assumes the oscillator level is sampled synchronously by the core clock
`timescale 1ns/100ps
module cpu_clock_mode_select
  import clk_mode_pkg::*;
#(
  parameter int SPAN_W = SPAN_W_DEFAULT
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // oscillator
  input wire logic osc_level_i,
  // configuration sources
  input wire logic long_hw_reset_i,
  input wire logic [7:0] port0_upper_byte_i,
  input wire logic sw_config_load_i,
  input wire logic [15:0] reset_control_reg_i,
  // cpu clock
  output cpu_clock_t cpu_clock_o,
  // status
  output clock_status_t clock_status_o,
  output logic [7:0] reset_config_latch_o,
  output logic [2:0] clock_mode_select_o
);

  if (SPAN_W < 8) begin : g_check
    $error("cpu_clock_mode_select: SPAN_W must be at least 8");
  end

  typedef struct packed {
    logic [7:0] latch;
    logic [2:0] mode_applied;
    gen_state_t state;
    cpu_clock_t clk;
    clock_status_t status;
    logic restart;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    latch: RESET_CONFIG_RESET,
    mode_applied: RESET_CONFIG_RESET[CFG_MSB:CFG_LSB],
    state: ST_RESTART,
    clk: '0,
    status: '0,
    restart: 1'b1
  };

  top_state_t s_reg;
  top_state_t s_next;

  logic osc_rise;
  logic osc_fall;
  logic pll_tick;
  logic pll_locked;
  logic [2:0] mode;
  logic [3:0] f_halves;
  logic [2:0] k_count;
  logic [6:0] inc_wide;

  assign mode = s_reg.latch[CFG_MSB:CFG_LSB];
  assign f_halves = factor_halves(s_reg.mode_applied);
  assign k_count = resync_count(s_reg.mode_applied);
  // increment scaled by the resync count, so the estimate needs no divider
  assign inc_wide = f_halves * k_count;

  osc_edge_detect u_osc_edge (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .level_i(osc_level_i),
    .rise_o(osc_rise),
    .fall_o(osc_fall)
  );

  pll_rate_gen #(
    .SPAN_W(SPAN_W)
  ) u_pll (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .restart_i(s_reg.restart),
    .increment_i(inc_wide[5:0]),
    .resync_count_i(k_count),
    .osc_edge_i(osc_rise | osc_fall),
    .tick_o(pll_tick),
    .locked_o(pll_locked)
  );

  always_comb begin
    logic next_level;
    next_level = s_reg.clk.level;
    s_next = s_reg;
    s_next.clk.rise = 1'b0;
    s_next.clk.fall = 1'b0;
    s_next.clk.half_tick = 1'b0;
    s_next.restart = 1'b0;

    if (long_hw_reset_i) begin
      s_next.latch = port0_upper_byte_i;
    end else if (sw_config_load_i) begin
      s_next.latch = reset_control_reg_i[RSTCTL_MSB:RSTCTL_LSB];
    end

    case (s_reg.state)
      ST_RESTART: begin
        if (s_reg.mode_applied == MODE_DIRECT) begin
          s_next.state = ST_DIRECT;
        end else if (s_reg.mode_applied == MODE_PRESCALE) begin
          s_next.state = ST_PRESCALE;
        end else begin
          s_next.state = ST_PLL_ACQUIRE;
        end
      end
      ST_DIRECT: begin
        next_level = osc_level_i;
      end
      ST_PRESCALE: begin
        if (osc_rise) begin
          next_level = ~s_reg.clk.level;
        end
      end
      ST_PLL_ACQUIRE: begin
        // clock is held until the first rate estimate exists
        if (pll_locked) begin
          s_next.state = ST_PLL_LOCKED;
        end
      end
      ST_PLL_LOCKED: begin
        if (pll_tick) begin
          next_level = ~s_reg.clk.level;
        end
      end
      default: begin
        s_next.state = ST_RESTART;
      end
    endcase

    // a new mode restarts generation; the level holds so no runt phase
    if (mode != s_reg.mode_applied) begin
      s_next.mode_applied = mode;
      s_next.state = ST_RESTART;
      s_next.restart = 1'b1;
      next_level = s_reg.clk.level;
    end

    s_next.clk.level = next_level;
    s_next.clk.rise = next_level & ~s_reg.clk.level;
    s_next.clk.fall = ~next_level & s_reg.clk.level;
    s_next.clk.half_tick = next_level ^ s_reg.clk.level;

    s_next.status.pll_enable = (s_next.state == ST_PLL_ACQUIRE) ||
                               (s_next.state == ST_PLL_LOCKED);
    s_next.status.pll_locked = (s_next.state == ST_PLL_LOCKED);
    s_next.status.prescale_active = (s_next.state == ST_PRESCALE);
    s_next.status.direct_active = (s_next.state == ST_DIRECT);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_reg <= TOP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cpu_clock_o = s_reg.clk;
  assign clock_status_o = s_reg.status;
  assign reset_config_latch_o = s_reg.latch;
  assign clock_mode_select_o = s_reg.mode_applied;

endmodule

// [design/osc_edge_detect.sv]
// transition detector for the sampled oscillator level
// assumes the level is already synchronous to the core clock
`timescale 1ns/100ps
module osc_edge_detect (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // sampled level
  input wire logic level_i,
  // transition pulses
  output logic rise_o,
  output logic fall_o
);

  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t s_reg;
  edge_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.prev = level_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      // sample tracks the pin through reset, so no false edge follows it
      s_reg.prev <= level_i;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rise_o = level_i & ~s_reg.prev;
  assign fall_o = ~level_i & s_reg.prev;

endmodule

// [design/pll_rate_gen.sv]
// digital stand-in for the phase locked loop: emits cpu clock edge ticks
// at factor times the oscillator transition rate
// assumes one oscillator transition pulse per input edge and far fewer
// ticks than core cycles; restart clears all lock state
`timescale 1ns/100ps
module pll_rate_gen
  import clk_mode_pkg::*;
#(
  parameter int SPAN_W = SPAN_W_DEFAULT
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // control
  input wire logic restart_i,
  input wire logic [5:0] increment_i,
  input wire logic [2:0] resync_count_i,
  // oscillator transitions
  input wire logic osc_edge_i,
  // edge ticks and lock
  output logic tick_o,
  output logic locked_o
);

  if (SPAN_W < 8) begin : g_check
    $error("pll_rate_gen: SPAN_W must be at least 8");
  end

  typedef struct packed {
    logic [SPAN_W:0] acc;
    logic [SPAN_W:0] modulus;
    logic [SPAN_W-1:0] span;
    logic [2:0] trans_cnt;
    logic measuring;
    logic locked;
    logic tick;
  } rate_state_t;

  rate_state_t s_reg;
  rate_state_t s_next;

  always_comb begin
    logic [SPAN_W-1:0] span_inc;
    logic [SPAN_W:0] measured;
    logic [SPAN_W+1:0] acc_sum;
    logic signed [SPAN_W+1:0] diff;
    logic signed [SPAN_W+1:0] step;
    span_inc = '0;
    measured = '0;
    acc_sum = '0;
    diff = '0;
    step = '0;
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (restart_i) begin
      s_next = '0;
    end else begin
      span_inc = (s_reg.span == '1) ? s_reg.span : s_reg.span + 1'b1;
      if (s_reg.measuring) begin
        s_next.span = span_inc;
      end
      if (s_reg.locked && (s_reg.modulus != '0)) begin
        acc_sum = {1'b0, s_reg.acc} + {{(SPAN_W-4){1'b0}}, increment_i};
        if (acc_sum >= {1'b0, s_reg.modulus}) begin
          acc_sum = acc_sum - {1'b0, s_reg.modulus};
          s_next.tick = 1'b1;
        end
        // a shrinking estimate must not leave the phase out of range
        s_next.acc = (acc_sum >= {1'b0, s_reg.modulus}) ? '0 : acc_sum[SPAN_W:0];
      end
      if (osc_edge_i) begin
        if (!s_reg.measuring) begin
          s_next.measuring = 1'b1;
          s_next.span = '0;
          s_next.trans_cnt = '0;
        end else if (s_reg.trans_cnt + 3'h1 >= resync_count_i) begin
          measured = {span_inc, 1'b0};
          s_next.span = '0;
          s_next.trans_cnt = '0;
          if (!s_reg.locked) begin
            s_next.modulus = measured;
            s_next.locked = 1'b1;
            s_next.acc = '0;
          end else begin
            diff = $signed({1'b0, measured}) - $signed({1'b0, s_reg.modulus});
            step = diff >>> SMOOTH_SHIFT;
            s_next.modulus = s_reg.modulus + step[SPAN_W:0];
          end
        end else begin
          s_next.trans_cnt = s_reg.trans_cnt + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;
  assign locked_o = s_reg.locked;

endmodule

// [sim/clk_mode_asserts.sv]
// assertions on the cpu clock mode selector ports
// assumes one core clock and a synchronous active high reset
`timescale 1ns/100ps
module clk_mode_asserts
  import clk_mode_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // inputs
  input wire logic osc_level_i,
  input wire logic long_hw_reset_i,
  input wire logic [7:0] port0_upper_byte_i,
  input wire logic sw_config_load_i,
  input wire logic [15:0] reset_control_reg_i,
  // outputs
  input wire cpu_clock_t cpu_clock_o,
  input wire clock_status_t clock_status_o,
  input wire logic [7:0] reset_config_latch_o,
  input wire logic [2:0] clock_mode_select_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic lv;
  logic ht;
  clock_status_t s;
  logic [2:0] m;
  assign lv = cpu_clock_o.level;
  assign ht = cpu_clock_o.half_tick;
  assign s = clock_status_o;
  assign m = clock_mode_select_o;
  edge_tick_a: assert property (ht == (cpu_clock_o.rise | cpu_clock_o.fall))
    else $error("tick not rise or fall");
  rise_level_a: assert property (cpu_clock_o.rise |-> lv)
    else $error("rise without high level");
  fall_level_a: assert property (cpu_clock_o.fall |-> !lv)
    else $error("fall without low level");
  level_pulse_a: assert property (ht == (lv != $past(lv)))
    else $error("level change without pulse");
  mode_follow_a: assert property (m == $past(reset_config_latch_o[7:5]))
    else $error("mode not from latch");
  strap_load_a: assert property (long_hw_reset_i |=>
    reset_config_latch_o == $past(port0_upper_byte_i)) else $error("strap not loaded");
  sw_load_a: assert property (sw_config_load_i && !long_hw_reset_i |=>
    reset_config_latch_o == $past(reset_control_reg_i[15:8])) else $error("sw not loaded");
  latch_hold_a: assert property (!sw_config_load_i && !long_hw_reset_i |=>
    $stable(reset_config_latch_o)) else $error("latch changed");
  mode_status_a: assert property (!$past(reset_i) && !$past(reset_i, 2) && $stable(m) |->
    s.pll_enable == (m != MODE_PRESCALE && m != MODE_DIRECT) &&
    s.prescale_active == (m == MODE_PRESCALE) && s.direct_active == (m == MODE_DIRECT))
    else $error("status does not match mode");
  lock_enable_a: assert property (s.pll_locked |-> s.pll_enable)
    else $error("locked while pll off");
  direct_follow_a: assert property (s.direct_active && $past(s.direct_active) &&
    $past(s.direct_active, 2) |-> lv == $past(osc_level_i)) else $error("direct lag");
  presc_edge_a: assert property (s.prescale_active && $past(s.prescale_active) &&
    $past(s.prescale_active, 2) |-> ht == ($past(osc_level_i) && !$past(osc_level_i, 2)))
    else $error("prescale edge wrong");
  cover property (cpu_clock_o.rise && s.pll_locked);
  cover property (ht && s.prescale_active);
  cover property (ht && s.direct_active);
endmodule
bind cpu_clock_mode_select clk_mode_asserts u_clk_mode_asserts (.core_clk_i, .reset_i,
  .osc_level_i, .long_hw_reset_i, .port0_upper_byte_i, .sw_config_load_i,
  .reset_control_reg_i, .cpu_clock_o, .clock_status_o, .reset_config_latch_o,
  .clock_mode_select_o);

// [sim/osc_model.sv]
// oscillator stand-in with programmable high and low times
// assumes the core clock oversamples it
`timescale 1ns/100ps
module osc_model (
  // clock
  input wire logic core_clk_i,
  // phase lengths in core cycles
  input wire logic [7:0] hi_i,
  input wire logic [7:0] lo_i,
  // oscillator
  output logic osc_o
);
  int cnt_reg = 0;
  initial osc_o = 1'b0;
  // free running, as a real oscillator never pauses
  always @(posedge core_clk_i) begin
    cnt_reg <= cnt_reg + 1;
    if (cnt_reg + 1 >= int'(osc_o ? hi_i : lo_i)) begin
      osc_o <= ~osc_o;
      cnt_reg <= 0;
    end
  end
endmodule

// [sim/testbench.sv]
// self-checking bench for the cpu clock mode selector
// assumes osc_model as oscillator and the bound checker
`timescale 1ns/100ps
module testbench;
  import clk_mode_pkg::*;
  typedef struct packed {logic [2:0] code; logic [2:0] stat; logic [7:0] edges;} row_t;
  // mode, {pll, prescale, direct}, edges in four oscillator periods
  row_t rows [8] = '{'{3'h7, 3'h4, 8'h20}, '{3'h6, 3'h4, 8'h18}, '{3'h5, 3'h4, 8'h10},
    '{3'h4, 3'h4, 8'h28}, '{3'h3, 3'h1, 8'h08}, '{3'h2, 3'h4, 8'h0C},
    '{3'h1, 3'h2, 8'h04}, '{3'h0, 3'h4, 8'h14}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic osc;
  logic lhr = 1'b0;
  logic swl = 1'b0;
  logic [7:0] p0 = 8'h00;
  logic [7:0] hi = 8'h14;
  logic [7:0] lo = 8'h14;
  logic [15:0] rc = 16'h0000;
  cpu_clock_t cc;
  clock_status_t st;
  logic [7:0] latch;
  logic [2:0] mode;
  int mismatches = 0;
  int comparisons = 0;
  int a, b;
  logic va, vb;
  always #2 clk = ~clk;
  osc_model u_osc_model (.core_clk_i(clk), .hi_i(hi), .lo_i(lo), .osc_o(osc));
  cpu_clock_mode_select #(.SPAN_W(16)) u_cpu_clock_mode_select (.core_clk_i(clk),
    .reset_i(rst), .osc_level_i(osc), .long_hw_reset_i(lhr), .port0_upper_byte_i(p0),
    .sw_config_load_i(swl), .reset_control_reg_i(rc), .cpu_clock_o(cc),
    .clock_status_o(st), .reset_config_latch_o(latch), .clock_mode_select_o(mode));
  task end_of_test;
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task fail(input string s);
    mismatches++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
      fail($sformatf("got %h exp %h", got, exp));
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task load(input logic [7:0] v);
    rc = {v, 8'h00};
    swl = 1'b1;
    cyc(1);
    swl = 1'b0;
    cyc(3);
  endtask
  // length of one cpu clock phase and its level
  task seg(output int n, output logic v);
    int i;
    for (i = 0; i < 300 && cc.half_tick !== 1'b1; i++)
      cyc(1);
    if (i >= 300) begin
      fail("no first clock edge");
      end_of_test;
    end
    v = cc.level;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (cc.half_tick !== 1'b1 && n < 300);
    if (n >= 300) begin
      fail("no clock edge");
      end_of_test;
    end
  endtask
  initial begin
    int i, n, t;
    cyc(3);
    rst = 1'b0;
    foreach (rows[k]) begin
      load({rows[k].code, 5'h0A});
      chk(latch, {rows[k].code, 5'h0A});
      chk(mode, rows[k].code);
      chk({st.pll_enable, st.prescale_active, st.direct_active}, rows[k].stat);
      if (rows[k].stat[2]) begin
        for (i = 0; i < 2000 && st.pll_locked !== 1'b1; i++)
          cyc(1);
        chk(st.pll_locked, 1'b1);
        if (i == 2000)
          end_of_test;
        cyc(400);
      end else
        cyc(100);
      n = 0;
      repeat (160) begin
        cyc(1);
        n += cc.half_tick;
      end
      // pll edges may jitter by a core cycle, so allow a small window
      t = rows[k].stat[2] ? 3 : 0;
      comparisons++;
      if (n < rows[k].edges - t || n > rows[k].edges + t)
        fail($sformatf("edges %0d", n));
    end
    // locked x4 clock must follow a faster input: 40 edges in five periods of 32
    load(8'hE0);
    for (i = 0; i < 2000 && st.pll_locked !== 1'b1; i++)
      cyc(1);
    chk(st.pll_locked, 1'b1);
    if (i == 2000)
      end_of_test;
    hi = 8'h10;
    lo = 8'h10;
    cyc(800);
    n = 0;
    repeat (160) begin
      cyc(1);
      n += cc.half_tick;
    end
    comparisons++;
    if (n < 37 || n > 43)
      fail($sformatf("resync edges %0d", n));
    hi = 8'h0C;
    lo = 8'h1C;
    p0 = 8'h7A;
    lhr = 1'b1;
    swl = 1'b1;
    rc = 16'h2000;
    cyc(1);
    lhr = 1'b0;
    swl = 1'b0;
    cyc(1);
    chk(latch, 8'h7A);
    cyc(100);
    seg(a, va);
    seg(b, vb);
    chk(va ? a : b, 8'h0C);
    chk(a + b, 8'h28);
    load(8'h20);
    cyc(100);
    seg(a, va);
    seg(b, vb);
    chk(a, 8'h28);
    chk(b, 8'h28);
    rst = 1'b1;
    cyc(2);
    chk(latch, 8'hFF);
    chk(mode, MODE_X4);
    chk({cc, st}, 8'h00);
    rst = 1'b0;
    cyc(20);
    end_of_test;
  end
endmodule
